//--- hdl/pmt_dev.sv
// telemetry readback device end of the link
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
module pmt_dev
  import pmt_pkg::*;
#(
  parameter int NPH     = 3,
  parameter int REFRESH = REFRESH_CYC
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // link
  pmt_link_if.dev                    link,
  // measured quantities, linear format
  input  wire logic [15:0]           temp_a,
  input  wire logic [15:0]           temp_b,
  input  wire logic [15:0]           vout_a,
  input  wire logic [15:0]           vout_b,
  input  wire logic [15:0]           vin,
  input  wire logic [15:0]           iin,
  input  wire logic [15:0]           iout_b,
  input  wire logic [NPH-1:0][15:0]  iout_ph,
  // current selections
  output logic [7:0]                 page_sel_r,
  output logic [7:0]                 phase_sel_r
);

  logic [2:0]             clk_s;
  logic [2:0]             frm_s;
  logic [1:0]             mosi_s;
  logic [4:0]             cnt_r;
  logic [FRAME_BITS-1:0]  rx_r;
  logic [WORD_W-1:0]      tx_r;
  logic                   miso_r;
  logic [7:0]             cml_r;
  logic                   alert_n_r;
  logic [31:0]            ref_cnt_r;
  logic [15:0]            pout_a_r;
  logic [15:0]            pout_b_r;
  logic [15:0]            pin_r;
  logic [15:0]            itot;
  logic [15:0]            iphase;
  logic [15:0]            rdval;
  logic                   lrise;
  logic                   lfall;
  logic                   fend;
  logic                   wr_ok;
  logic                   inv_evt;
  logic                   clr_evt;
  logic [CODE_W-1:0]      hcode;
  logic [CODE_W-1:0]      wcode;
  logic                   sel_b;

  // shrink mantissa into 11 bits, bumping the exponent
  function automatic logic [15:0] lin_norm(
    input logic signed [21:0] m,
    input logic signed [6:0]  e
  );
    logic signed [21:0] mm;
    logic signed [6:0]  ee;
    mm = m;
    ee = e;
    for (int i = 0; i < 11; i++) begin
      if (mm[21:MAN_MSB] != {12{mm[MAN_MSB]}}) begin
        mm = mm >>> 1;
        ee = ee + 7'sd1;
      end
    end
    // exponent overflow beyond 5 bits wraps; not reachable for sane inputs
    return {ee[4:0], mm[MAN_MSB:0]};
  endfunction

  function automatic logic [15:0] lin_mul(
    input logic [15:0] a,
    input logic [15:0] b
  );
    logic signed [21:0] p;
    logic signed [6:0]  e;
    p = $signed({{11{a[MAN_MSB]}}, a[MAN_MSB:0]})
      * $signed({{11{b[MAN_MSB]}}, b[MAN_MSB:0]});
    e = $signed({{2{a[EXP_MSB]}}, a[EXP_MSB:EXP_LSB]})
      + $signed({{2{b[EXP_MSB]}}, b[EXP_MSB:EXP_LSB]});
    return lin_norm(p, e);
  endfunction

  // link pins cross into ref_clk
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      clk_s  <= 3'h0;
      frm_s  <= 3'h7;
      mosi_s <= 2'h0;
    end else begin
      clk_s  <= {clk_s[1:0], link.lclk};
      frm_s  <= {frm_s[1:0], link.frame_n};
      mosi_s <= {mosi_s[0], link.mosi};
    end
  end

  assign lrise = clk_s[1] & ~clk_s[2];
  assign lfall = ~clk_s[1] & clk_s[2];
  assign fend  = frm_s[1] & ~frm_s[2];
  assign hcode = rx_r[HDR_BITS-1:1];
  assign wcode = rx_r[FRAME_BITS-1:FRAME_BITS-CODE_W];
  assign wr_ok = fend && (cnt_r == 5'(FRAME_BITS)) && !rx_r[WORD_W];

  // bit capture on link rising edges
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_r <= 5'h00;
      rx_r  <= '0;
    end else if (frm_s[1]) begin
      cnt_r <= 5'h00;
    end else if (lrise && cnt_r != 5'(FRAME_BITS)) begin
      rx_r  <= {rx_r[FRAME_BITS-2:0], mosi_s[1]};
      cnt_r <= cnt_r + 5'h01;
    end
  end

  always_comb begin
    iphase = 16'h0000;
    if (phase_sel_r == PHASE_TOTAL || phase_sel_r == PHASE_ALL) begin
      iphase = itot;
    end else begin
      for (int i = 0; i < NPH; i++) begin
        if (phase_sel_r == 8'(i)) begin
          iphase = iout_ph[i];
        end
      end
    end
  end

  // phase sum, phases share one exponent
  always_comb begin
    logic signed [21:0] acc;
    acc = 22'sh0;
    for (int i = 0; i < NPH; i++) begin
      acc = acc + $signed({{11{iout_ph[i][MAN_MSB]}},
                           iout_ph[i][MAN_MSB:0]});
    end
    itot = lin_norm(acc,
      $signed({{2{iout_ph[0][EXP_MSB]}}, iout_ph[0][EXP_MSB:EXP_LSB]}));
  end

  // broadcast page reads answer with channel A
  assign sel_b = (page_sel_r == PAGE_B);

  // answer word for the command in the header
  always_comb begin
    rdval = 16'h0000;
    case (hcode)
      CMD_PAGE:        rdval = {8'h00, page_sel_r};
      CMD_PHASE:       rdval = {8'h00, phase_sel_r};
      CMD_STATUS_CML:  rdval = {8'h00, cml_r};
      // one-bit flag placed directly, no shift of a 1-bit operand
      CMD_STATUS_WORD: rdval[WORD_CML_BIT] = |cml_r;
      CMD_TEMP:        rdval = sel_b ? temp_b : temp_a;
      CMD_POUT:        rdval = sel_b ? pout_b_r : pout_a_r;
      CMD_PIN:         rdval = pin_r;
      CMD_VOUT_LIN:    rdval = sel_b ? vout_b : vout_a;
      CMD_IOUT:        rdval = sel_b ? iout_b : iphase;
      default:         rdval = 16'h0000;
    endcase
  end

  // answer shifted out after link falling edges
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_r   <= 16'h0000;
      miso_r <= 1'b0;
    end else if (frm_s[1]) begin
      miso_r <= 1'b0;
    end else if (lfall && rx_r[0] && cnt_r == 5'(HDR_BITS)) begin
      // answer word for the header command sent msb first
      miso_r <= rdval[WORD_W-1];
      tx_r   <= {rdval[WORD_W-2:0], 1'b0};
    end else if (lfall && cnt_r > 5'(HDR_BITS)) begin
      miso_r <= tx_r[WORD_W-1];
      tx_r   <= {tx_r[WORD_W-2:0], 1'b0};
    end
  end

  always_comb begin
    inv_evt = 1'b0;
    clr_evt = 1'b0;
    if (wr_ok) begin
      case (wcode)
        CMD_IOUT, CMD_TEMP, CMD_POUT, CMD_PIN, CMD_VOUT_LIN:
          inv_evt = 1'b1;
        CMD_CLEAR:
          clr_evt = 1'b1;
        default: ;
      endcase
    end
  end

  // page and phase take only their own writes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      page_sel_r  <= SEL_RESET;
      phase_sel_r <= SEL_RESET;
    end else if (wr_ok && wcode == CMD_PAGE) begin
      page_sel_r  <= rx_r[7:0];
    end else if (wr_ok && wcode == CMD_PHASE) begin
      phase_sel_r <= rx_r[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cml_r <= 8'h00;
    end else if (inv_evt) begin
      cml_r[CML_INV_BIT] <= 1'b1;
    end else if (clr_evt) begin
      cml_r <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      alert_n_r <= 1'b1;
    end else begin
      alert_n_r <= ~(|cml_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ref_cnt_r <= 32'h0000_0000;
    end else if (ref_cnt_r == 32'(REFRESH - 1)) begin
      ref_cnt_r <= 32'h0000_0000;
    end else begin
      ref_cnt_r <= ref_cnt_r + 32'h0000_0001;
    end
  end

  // power words are sampled, so reads never see a half update
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pout_a_r <= 16'h0000;
      pout_b_r <= 16'h0000;
      pin_r    <= 16'h0000;
    end else if (ref_cnt_r == 32'(REFRESH - 1)) begin
      pout_a_r <= lin_mul(vout_a, itot);
      pout_b_r <= lin_mul(vout_b, iout_b);
      pin_r    <= lin_mul(vin, iin);
    end
  end

  assign link.miso    = miso_r;
  assign link.alert_n = alert_n_r;

endmodule

//--- shared/pmt_pkg.sv
// shared constants and types for the telemetry readback link
package pmt_pkg;
  // timing
  localparam int CLK_MHZ     = 100;
  localparam int REFRESH_US  = 1200;
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
  localparam int HOST_HALF   = 8;
  // frame layout: code, read flag, data word, msb first
  localparam int CODE_W     = 8;
  localparam int WORD_W     = 16;
  localparam int HDR_BITS   = 9;
  localparam int FRAME_BITS = 25;
  // linear word fields
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  // command codes
  localparam logic [7:0] CMD_PAGE        = 8'h00;
  localparam logic [7:0] CMD_CLEAR       = 8'h03;
  localparam logic [7:0] CMD_PHASE       = 8'h04;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_CML  = 8'h7E;
  localparam logic [7:0] CMD_IOUT        = 8'h8C;
  localparam logic [7:0] CMD_TEMP        = 8'h8D;
  localparam logic [7:0] CMD_POUT        = 8'h96;
  localparam logic [7:0] CMD_PIN         = 8'h97;
  localparam logic [7:0] CMD_VOUT_LIN    = 8'hD4;
  // page and phase selectors
  localparam logic [7:0] PAGE_A      = 8'h00;
  localparam logic [7:0] PAGE_B      = 8'h01;
  localparam logic [7:0] PAGE_ALL    = 8'hFF;
  localparam logic [7:0] PHASE_TOTAL = 8'h80;
  localparam logic [7:0] PHASE_ALL   = 8'hFF;
  localparam logic [7:0] SEL_RESET   = 8'h00;
  // status bits
  localparam int CML_INV_BIT = 7;
  localparam int WORD_CML_BIT = 1;
  // host register map
  localparam logic [7:0] HR_CMD    = 8'h00;
  localparam logic [7:0] HR_STATUS = 8'h04;
  localparam logic [7:0] HR_RDATA  = 8'h08;
  localparam logic [7:0] HR_IST    = 8'h0C;
  localparam logic [7:0] HR_ICLR   = 8'h10;
  localparam logic [7:0] HR_IEN    = 8'h14;
  localparam int HI_DONE  = 0;
  localparam int HI_ALERT = 1;
  localparam int HC_RD    = 8;
  localparam int HC_DLSB  = 16;
  // host link sequencer
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_RUN   = 2'b11,
    H_DONE  = 2'b10
  } pmt_hstate_t;
endpackage

//--- shared/pmt_link_if.sv
// serial link between telemetry device and host
`timescale 1ns/10ps
interface pmt_link_if;
  logic lclk;
  logic frame_n;
  logic mosi;
  logic miso;
  logic alert_n;
  modport dev (input lclk, input frame_n, input mosi,
               output miso, output alert_n);
  modport hst (output lclk, output frame_n, output mosi,
               input miso, input alert_n);
endinterface

//--- hdl/pmt_host.sv
// telemetry link host end with software register port
`timescale 1ns/10ps
module pmt_host
  import pmt_pkg::*;
#(
  parameter int HALF = HOST_HALF
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  // interrupt
  output logic              irq,
  // link
  pmt_link_if.hst           link
);

  pmt_hstate_t            state_r;
  logic [7:0]             div_r;
  logic [4:0]             bit_r;
  logic [FRAME_BITS-1:0]  sh_r;
  logic [WORD_W-1:0]      rx_r;
  logic [WORD_W-1:0]      rdata_r;
  logic                   rd_r;
  logic                   lclk_r;
  logic                   frame_n_r;
  logic                   mosi_r;
  logic [1:0]             miso_s;
  logic [2:0]             alert_s;
  logic [1:0]             ist_r;
  logic [1:0]             ien_r;
  logic                   tick;
  logic                   start;
  logic                   done_evt;
  logic                   alert_evt;

  assign tick      = (div_r == 8'(HALF - 1));
  assign start     = reg_wr && reg_addr == HR_CMD && state_r == H_IDLE;
  assign done_evt  = (state_r == H_DONE) && tick;
  assign alert_evt = ~alert_s[1] & alert_s[2];

  // device pins cross into ref_clk
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      miso_s  <= 2'h0;
      alert_s <= 3'h7;
    end else begin
      miso_s  <= {miso_s[0], link.miso};
      alert_s <= {alert_s[1:0], link.alert_n};
    end
  end

  // frame sequencer and clock divider
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r   <= H_IDLE;
      div_r     <= 8'h00;
      bit_r     <= 5'h00;
      sh_r      <= '0;
      rx_r      <= 16'h0000;
      rd_r      <= 1'b0;
      lclk_r    <= 1'b0;
      frame_n_r <= 1'b1;
      mosi_r    <= 1'b0;
    end else begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      case (state_r)
        H_IDLE: begin
          div_r <= 8'h00;
          if (start) begin
            sh_r      <= {reg_wdata[CODE_W-1:0], reg_wdata[HC_RD],
                          reg_wdata[HC_DLSB +: WORD_W]};
            rd_r      <= reg_wdata[HC_RD];
            mosi_r    <= reg_wdata[CODE_W-1];
            bit_r     <= 5'h00;
            frame_n_r <= 1'b0;
            state_r   <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (tick) begin
            lclk_r  <= 1'b1;
            state_r <= H_RUN;
          end
        end
        H_RUN: begin
          if (tick && !lclk_r) begin
            lclk_r <= 1'b1;
            if (rd_r && bit_r >= 5'(HDR_BITS)) begin
              rx_r <= {rx_r[WORD_W-2:0], miso_s[1]};
            end
          end else if (tick) begin
            lclk_r <= 1'b0;
            if (bit_r == 5'(FRAME_BITS - 1)) begin
              state_r <= H_DONE;
            end else begin
              bit_r  <= bit_r + 5'h01;
              mosi_r <= sh_r[FRAME_BITS-2];
              sh_r   <= {sh_r[FRAME_BITS-2:0], 1'b0};
            end
          end
        end
        H_DONE: begin
          if (tick) begin
            frame_n_r <= 1'b1;
            mosi_r    <= 1'b0;
            state_r   <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // last answer word, kept until the next read frame ends
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else if (done_evt && rd_r) begin
      rdata_r <= rx_r;
    end
  end

  // sticky events; a new event beats a clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ist_r <= 2'h0;
      ien_r <= 2'h0;
    end else begin
      ist_r <= (ist_r & ~((reg_wr && reg_addr == HR_ICLR) ?
                          reg_wdata[1:0] : 2'h0))
             | {alert_evt, done_evt};
      if (reg_wr && reg_addr == HR_IEN) begin
        ien_r <= reg_wdata[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_r & ien_r);
    end
  end

  // read data valid only the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_addr == HR_STATUS) begin
      reg_rdata <= {30'h0, ~alert_s[1], state_r != H_IDLE};
    end else if (reg_addr == HR_RDATA) begin
      reg_rdata <= {16'h0000, rdata_r};
    end else if (reg_addr == HR_IST) begin
      reg_rdata <= {30'h0, ist_r};
    end else if (reg_addr == HR_IEN) begin
      reg_rdata <= {30'h0, ien_r};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  assign link.lclk    = lclk_r;
  assign link.frame_n = frame_n_r;
  assign link.mosi    = mosi_r;

endmodule

//--- test/pmt_chk.sv
// link checker for the telemetry readback interface
`timescale 1ns/10ps
module pmt_chk
  import pmt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // link
  input wire logic lclk,
  input wire logic frame_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic alert_n
);
  logic [5:0]  cnt_r;
  logic [24:0] sh_r;
  logic        rd_r;
  logic        bad_r;
  wire  [7:0]  code_w = sh_r[24:17];
  wire         ro_w   = code_w == CMD_IOUT || code_w == CMD_TEMP ||
                        code_w == CMD_POUT || code_w == CMD_PIN ||
                        code_w == CMD_VOUT_LIN;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // rises counted per frame, cleared at frame start
  always_ff @(posedge ref_clk) begin
    if (!rst_b || $fell(frame_n))
      cnt_r <= 6'h00;
    else if ($rose(lclk))
      cnt_r <= cnt_r + 6'h01;
  end

  // frame capture, sampled on link clock rises, where the device captures bits
  always_ff @(posedge ref_clk) begin
    if ($rose(lclk))
      sh_r <= {sh_r[23:0], mosi};
    if ($rose(lclk) && cnt_r == 6'h08)
      rd_r <= mosi;
  end

  // bad write seen, valid until the next frame starts
  always_ff @(posedge ref_clk) begin
    if (!rst_b || $fell(frame_n))
      bad_r <= 1'b0;
    else if ($rose(frame_n))
      bad_r <= cnt_r == 6'h19 && !sh_r[16] && ro_w;
  end

  chk_reset_idle: assert property (
    $rose(rst_b) |-> frame_n && !lclk && alert_n && !miso)
    else $error("link not idle after reset");
  chk_clock_idle: assert property (
    frame_n |-> !lclk)
    else $error("link clock moves outside a frame");
  chk_clock_half: assert property (
    $rose(lclk) |-> lclk [*8] ##1 !lclk)
    else $error("link clock high phase wrong");
  chk_frame_lead: assert property (
    $fell(frame_n) |-> (!lclk) [*8] ##1 lclk)
    else $error("first link clock rise misplaced");
  chk_frame_bits: assert property (
    $rose(frame_n) |-> cnt_r == 6'h19)
    else $error("frame does not hold a full word");
  chk_data_stable: assert property (
    lclk && $past(lclk) |-> $stable({mosi, miso}))
    else $error("data moved while link clock high");
  chk_miso_quiet: assert property (
    !frame_n && (cnt_r < 6'h09 || !rd_r) |-> !miso)
    else $error("device drove data outside a read answer");
  chk_alert_raise: assert property (
    $rose(frame_n) && cnt_r == 6'h19 && !sh_r[16] && ro_w
      |-> ##[1:8] !alert_n)
    else $error("no alert after read-only write");
  chk_alert_cause: assert property (
    $fell(alert_n) |-> bad_r)
    else $error("alert raised without a bad write");
endmodule

//--- test/tb_top.sv
// bench joining both link ends under register-port stimulus
`timescale 1ns/10ps
module tb_top
  import pmt_pkg::*;
;
  logic             ref_clk   = 1'b0;
  logic             rst_b     = 1'b0;
  logic [7:0]       reg_addr  = 8'h00;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_wr    = 1'b0;
  logic             reg_rd    = 1'b0;
  logic [31:0]      reg_rdata;
  logic             irq;
  logic [15:0]      temp_a    = 16'hF832;
  logic [15:0]      temp_b    = 16'h0019;
  logic [15:0]      vout_a    = 16'hF802;
  logic [15:0]      vout_b    = 16'h0002;
  logic [15:0]      vin       = 16'h000C;
  logic [15:0]      iin       = 16'h0002;
  logic [15:0]      iout_b    = 16'h0005;
  logic [2:0][15:0] iout_ph   = {16'h0003, 16'h0002, 16'h0001};
  logic [7:0]       page_sel_r;
  logic [7:0]       phase_sel_r;
  int               bad_count = 0;
  int               cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  pmt_link_if i_pmt_link_if ();
  // short refresh keeps power updates inside a few frames
  pmt_dev #(.NPH(3), .REFRESH(20)) i_pmt_dev (
    .ref_clk(ref_clk), .rst_b(rst_b), .link(i_pmt_link_if.dev),
    .temp_a(temp_a), .temp_b(temp_b), .vout_a(vout_a), .vout_b(vout_b),
    .vin(vin), .iin(iin), .iout_b(iout_b), .iout_ph(iout_ph),
    .page_sel_r(page_sel_r), .phase_sel_r(phase_sel_r));
  pmt_host #(.HALF(8)) i_pmt_host (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .link(i_pmt_link_if.hst));
  pmt_chk i_pmt_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .lclk(i_pmt_link_if.lclk),
    .frame_n(i_pmt_link_if.frame_n), .mosi(i_pmt_link_if.mosi),
    .miso(i_pmt_link_if.miso), .alert_n(i_pmt_link_if.alert_n));

  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // one link frame; polls busy, so a hung frame shows as a mismatch
  task automatic xfer(input logic [7:0] c, input logic r,
                      input logic [15:0] d, output logic [15:0] q);
    logic [31:0] s;
    int          n;
    wr(HR_CMD, {d, 7'h00, r, c});
    s = 32'h1;
    n = 0;
    while (s[0] !== 1'b0 && n < 400) begin
      rd(HR_STATUS, s);
      n++;
    end
    cmp("busy", 32'h0, s[0]);
    repeat (16) @(posedge ref_clk);
    rd(HR_RDATA, s);
    q = s[15:0];
    rd(HR_IST, s);
    cmp("done", 32'h1, s[HI_DONE]);
    wr(HR_ICLR, 32'h1);
  endtask

  task automatic rq(input logic [7:0] c, input logic [15:0] e,
                    input string n);
    logic [15:0] q;
    xfer(c, 1'b1, 16'h0000, q);
    cmp(n, e, q);
  endtask

  task automatic sel(input logic [7:0] p, input logic [7:0] h);
    logic [15:0] q;
    xfer(CMD_PAGE, 1'b0, {8'h00, p}, q);
    xfer(CMD_PHASE, 1'b0, {8'h00, h}, q);
    cmp("page_sel", p, page_sel_r);
    cmp("phase_sel", h, phase_sel_r);
  endtask

  task automatic t_reset();
    logic [31:0] s;
    cmp("page_rst", 8'h00, page_sel_r);
    cmp("phase_rst", 8'h00, phase_sel_r);
    cmp("irq_rst", 1'b0, irq);
    rd(HR_STATUS, s);
    cmp("status_rst", 32'h0, s);
    rd(8'h20, s);
    cmp("unmapped", 32'h0, s);
    rd(HR_ICLR, s);
    cmp("iclr_read", 32'h0, s);
  endtask

  task automatic t_paged();
    logic [7:0] pg [3] = '{PAGE_A, PAGE_B, PAGE_ALL};
    for (int i = 0; i < 3; i++) begin
      sel(pg[i], PHASE_TOTAL);
      rq(CMD_TEMP, i == 1 ? temp_b : temp_a, "temp");
      rq(CMD_VOUT_LIN, i == 1 ? vout_b : vout_a, "vlin");
      rq(CMD_POUT, i == 1 ? 16'h000A : 16'hF80C, "pout");
      rq(CMD_PIN, 16'h0018, "pin");
    end
    @(posedge ref_clk);
    vin    <= 16'h000D;
    vout_a <= 16'hF804;
    rq(CMD_PIN, 16'h001A, "pin_new");
    rq(CMD_POUT, 16'hF818, "pout_new");
    rq(CMD_VOUT_LIN, 16'hF804, "vlin_live");
  endtask

  task automatic t_phase();
    for (int i = 0; i < 4; i++) begin
      sel(PAGE_A, 8'(i));
      rq(CMD_IOUT, i < 3 ? iout_ph[i] : 16'h0000, "phase");
    end
    sel(PAGE_A, PHASE_TOTAL);
    rq(CMD_IOUT, 16'h0006, "total");
    sel(PAGE_A, PHASE_ALL);
    rq(CMD_IOUT, 16'h0006, "all");
    sel(PAGE_B, 8'h01);
    rq(CMD_IOUT, iout_b, "page_b");
  endtask

  task automatic t_bad();
    logic [7:0]  ro [5] = '{CMD_IOUT, CMD_TEMP, CMD_POUT, CMD_PIN,
                            CMD_VOUT_LIN};
    logic [15:0] q;
    logic [31:0] s;
    wr(HR_IEN, 32'h0);
    for (int i = 0; i < 5; i++) begin
      xfer(ro[i], 1'b0, 16'h1234, q);
      rd(HR_STATUS, s);
      cmp("alert_on", 32'h1, s[1]);
      xfer(CMD_STATUS_CML, 1'b1, 16'h0000, q);
      cmp("cml_flag", 32'h1, q[CML_INV_BIT]);
      xfer(CMD_STATUS_WORD, 1'b1, 16'h0000, q);
      cmp("word_flag", 32'h1, q[WORD_CML_BIT]);
      xfer(CMD_CLEAR, 1'b0, 16'h0000, q);
      rd(HR_STATUS, s);
      cmp("alert_off", 32'h0, s[1]);
    end
    rq(CMD_POUT, 16'h000A, "kept");
    rd(HR_IST, s);
    cmp("ist_alert", 32'h1, s[HI_ALERT]);
    cmp("irq_masked", 1'b0, irq);
    wr(HR_IEN, 32'h2);
    rd(HR_IEN, s);
    cmp("ien_read", 32'h2, s);
    repeat (3) @(posedge ref_clk);
    cmp("irq_on", 1'b1, irq);
    wr(HR_ICLR, 32'h2);
    repeat (3) @(posedge ref_clk);
    cmp("irq_off", 1'b0, irq);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_paged();
    t_phase();
    t_bad();
    end_sim();
  end

  // about 60 frames of some 450 cycles each are expected
  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end
endmodule
